// ### verilog/svc_map.svh
/*
  Constants of the service-mode exit, save and restore handler: characters,
  reset values and the hold time before a non-immediate exit.
  Assumes the clock runs at 125 MHz.
*/
`ifndef SVC_MAP_SVH
`define SVC_MAP_SVH

// ==========================================================================
// Characters of the command dialogue
// ==========================================================================
`define CH_CR        8'h0D
`define CH_SPACE     8'h20
`define CH_COMMA     8'h2C
`define CH_SAVE      8'h73
`define CH_EXIT      8'h78
`define CH_RESTORE   8'h7A
`define CH_YES       8'h59
`define CH_NO        8'h4E
`define CH_T_NORMAL  8'h6E
`define CH_T_INIT    8'h69
`define CH_T_NOW_NRM 8'h4E
`define CH_T_NOW_INI 8'h49

// ==========================================================================
// Timing
// ==========================================================================
`define CLOCK_KHZ    125000
`define HOLD_TIME_MS 3000
`define HOLD_CYCLES  (`HOLD_TIME_MS * `CLOCK_KHZ)

// ==========================================================================
// Reset values
// ==========================================================================
`define COUNT_RESET  2'h0
`define CHAR_RESET   8'h00

`endif

// ### verilog/svc_pkg.sv
/*
  Types of the service-mode exit, save and restore handler.
  Assumes nothing of its surroundings.
*/
package svc_pkg;

  typedef enum logic [7:0] {
    ST_IDLE      = 8'h01,
    ST_LINE      = 8'h02,
    ST_CONF_SAVE = 8'h04,
    ST_CONF_EXIT = 8'h08,
    ST_CONF_REST = 8'h10,
    ST_CONF_TX   = 8'h20,
    ST_HOLD      = 8'h40,
    ST_LEFT      = 8'h80
  } state_t;

  typedef enum logic [3:0] {
    MSG_NONE         = 4'h0,
    MSG_PROMPT       = 4'h1,
    MSG_SAVE_CONFIRM = 4'h2,
    MSG_SAVE_DONE    = 4'h3,
    MSG_SAVE_ABORTED = 4'h4,
    MSG_ERR_UNKNOWN  = 4'h5,
    MSG_ERR_COUNT    = 4'h6,
    MSG_ERR_PARAM    = 4'h7,
    MSG_EXIT_CONFIRM = 4'h8,
    MSG_TO_NORMAL    = 4'h9,
    MSG_TO_INIT      = 4'hA,
    MSG_REST_CONFIRM = 4'hB,
    MSG_TX_CONFIRM   = 4'hC,
    MSG_TX_NEW       = 4'hD,
    MSG_APPLYING     = 4'hE,
    MSG_APPLIED      = 4'hF
  } msg_t;

endpackage : svc_pkg

// ### verilog/hold_if.sv
/*
  Handshake between the command handler and its exit hold timer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface hold_if;
  logic start;
  logic done;
  modport ctl (output start, input  done);
  modport tmr (input  start, output done);
endinterface : hold_if

// ### verilog/hold_timer.sv
/*
  Hold timer: after a start pulse counts a fixed number of cycles and then
  gives a one-cycle done pulse.
  Assumes start is not repeated while a count is running.
*/
`timescale 1ns/1ps
`include "svc_map.svh"
module hold_timer #(
  parameter logic [31:0] HOLD_CYCLES = `HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Handshake
  hold_if.tmr      hold
);
  logic [31:0] count;
  logic        busy;
  logic        done;
  logic [31:0] next_count;
  logic        next_busy;
  logic        next_done;

  always_comb begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (hold.start) begin
      next_busy  = 1'b1;
      next_count = 32'h0000_0001;
    end else if (busy) begin
      if (count >= HOLD_CYCLES) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 32'h0000_0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

  assign hold.done = done;
endmodule : hold_timer

// ### verilog/service_mode_exit_restore.sv
/*
  Service-mode command handler for the save confirmation, exit and
  restore-to-factory commands. Takes received characters and emits message
  codes; a separate formatter turns codes into text.
  Assumes characters and message ready come from logic on the same clock, and
  that the configuration store reports whether live settings differ.
*/
`timescale 1ns/1ps
`include "svc_map.svh"
module service_mode_exit_restore #(
  parameter logic [31:0] HOLD_CYCLES = `HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Received characters
  input  wire logic [7:0]   rx_data,
  input  wire logic         rx_valid,
  output logic              rx_ready,
  // Message codes to the text formatter
  output svc_pkg::msg_t     msg_code,
  output logic              msg_valid,
  input  wire logic         msg_ready,
  // Configuration store
  input  wire logic         params_differ,
  input  wire logic         tx_settings_differ,
  output logic              save_req,
  output logic              load_flash,
  output logic              apply_defaults,
  // Mode control
  input  wire logic         enter_service,
  output logic              enter_normal,
  output logic              enter_init
);
  // ========================================================================
  // State
  // ========================================================================
  svc_pkg::state_t state;
  svc_pkg::state_t next_state;
  svc_pkg::msg_t   q [4];
  svc_pkg::msg_t   next_q [4];
  logic [7:0]      cmd;
  logic [7:0]      next_cmd;
  logic [7:0]      first_ch;
  logic [7:0]      next_first_ch;
  logic [7:0]      second_ch;
  logic [7:0]      next_second_ch;
  logic [1:0]      n_after;
  logic [1:0]      next_n_after;
  logic            comma;
  logic            next_comma;
  logic            to_init;
  logic            next_to_init;
  logic            timing;
  logic            next_timing;
  logic            next_save_req;
  logic            next_load_flash;
  logic            next_apply_defaults;
  logic            next_enter_normal;
  logic            next_enter_init;
  logic            q_empty;
  logic            take;

  hold_if hold ();

  hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clock (clock),
    .rst   (rst),
    .hold  (hold.tmr)
  );

  assign q_empty   = (q[0] == svc_pkg::MSG_NONE);
  assign msg_code  = q[0];
  assign msg_valid = !q_empty;
  // Input is held off while a response is still going out, so a reply can
  // never be judged against a prompt the host has not yet seen.
  assign rx_ready  = q_empty && (state != svc_pkg::ST_HOLD) && (state != svc_pkg::ST_LEFT);
  assign take      = rx_valid && rx_ready;

  // Loads up to four message codes in order; unused slots stay empty.
  function automatic void load(output svc_pkg::msg_t d [4], input svc_pkg::msg_t a,
                               input svc_pkg::msg_t b, input svc_pkg::msg_t c,
                               input svc_pkg::msg_t e);
    d[0] = a;
    d[1] = b;
    d[2] = c;
    d[3] = e;
  endfunction : load

  // ========================================================================
  // Next-state logic
  // ========================================================================
  always_comb begin
    next_state          = state;
    next_q              = q;
    next_cmd            = cmd;
    next_first_ch       = first_ch;
    next_second_ch      = second_ch;
    next_n_after        = n_after;
    next_comma          = comma;
    next_to_init        = to_init;
    next_timing         = timing;
    next_save_req       = 1'b0;
    next_load_flash     = 1'b0;
    next_apply_defaults = 1'b0;
    next_enter_normal   = 1'b0;
    next_enter_init     = 1'b0;
    hold.start          = 1'b0;

    if (msg_valid && msg_ready) begin
      next_q[0] = q[1];
      next_q[1] = q[2];
      next_q[2] = q[3];
      next_q[3] = svc_pkg::MSG_NONE;
    end

    unique case (state)
      svc_pkg::ST_IDLE: begin
        if (take) begin
          if (rx_data == `CH_CR) begin
            load(next_q, svc_pkg::MSG_PROMPT, svc_pkg::MSG_NONE,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
          end else begin
            next_cmd     = rx_data;
            next_n_after = `COUNT_RESET;
            next_comma   = 1'b0;
            next_state   = svc_pkg::ST_LINE;
          end
        end
      end
      svc_pkg::ST_LINE: begin
        if (take && rx_data != `CH_CR) begin
          if (n_after == 2'h0) next_first_ch = rx_data;
          if (n_after == 2'h1) next_second_ch = rx_data;
          if (n_after != 2'h3) next_n_after = n_after + 2'h1;
          if (rx_data == `CH_COMMA) next_comma = 1'b1;
        end else if (take) begin
          next_state = svc_pkg::ST_IDLE;
          if (cmd == `CH_SAVE || cmd == `CH_RESTORE) begin
            if (n_after != 2'h0) begin
              load(next_q, svc_pkg::MSG_ERR_COUNT, svc_pkg::MSG_PROMPT,
                   svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
            end else if (cmd == `CH_SAVE) begin
              load(next_q, svc_pkg::MSG_SAVE_CONFIRM, svc_pkg::MSG_NONE,
                   svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
              next_state = svc_pkg::ST_CONF_SAVE;
            end else begin
              load(next_q, svc_pkg::MSG_REST_CONFIRM, svc_pkg::MSG_NONE,
                   svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
              next_state = svc_pkg::ST_CONF_REST;
            end
          end else if (cmd == `CH_EXIT) begin
            if (n_after < 2'h2 || first_ch != `CH_SPACE || comma) begin
              load(next_q, svc_pkg::MSG_ERR_COUNT, svc_pkg::MSG_PROMPT,
                   svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
            end else if (n_after == 2'h2 &&
                         (second_ch == `CH_T_NORMAL || second_ch == `CH_T_INIT)) begin
              next_to_init = (second_ch == `CH_T_INIT);
              if (params_differ) begin
                load(next_q, svc_pkg::MSG_EXIT_CONFIRM, svc_pkg::MSG_NONE,
                     svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
                next_state = svc_pkg::ST_CONF_EXIT;
              end else begin
                load(next_q, (second_ch == `CH_T_INIT) ? svc_pkg::MSG_TO_INIT
                     : svc_pkg::MSG_TO_NORMAL, svc_pkg::MSG_NONE,
                     svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
                next_timing = 1'b0;
                next_state  = svc_pkg::ST_HOLD;
              end
            end else if (n_after == 2'h2 &&
                         (second_ch == `CH_T_NOW_NRM || second_ch == `CH_T_NOW_INI)) begin
              load(next_q, (second_ch == `CH_T_NOW_INI) ? svc_pkg::MSG_TO_INIT
                   : svc_pkg::MSG_TO_NORMAL, svc_pkg::MSG_NONE,
                   svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
              next_enter_normal = (second_ch == `CH_T_NOW_NRM);
              next_enter_init   = (second_ch == `CH_T_NOW_INI);
              next_load_flash   = (second_ch == `CH_T_NOW_INI);
              next_state        = svc_pkg::ST_LEFT;
            end else begin
              load(next_q, svc_pkg::MSG_ERR_PARAM, svc_pkg::MSG_PROMPT,
                   svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
            end
          end else begin
            load(next_q, svc_pkg::MSG_ERR_UNKNOWN, svc_pkg::MSG_PROMPT,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
          end
        end
      end
      svc_pkg::ST_CONF_SAVE: begin
        if (take) begin
          next_state = svc_pkg::ST_IDLE;
          if (rx_data == `CH_YES) begin
            next_save_req = 1'b1;
            load(next_q, svc_pkg::MSG_SAVE_DONE, svc_pkg::MSG_PROMPT,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
          end else if (rx_data == `CH_NO) begin
            load(next_q, svc_pkg::MSG_SAVE_ABORTED, svc_pkg::MSG_PROMPT,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
          end else begin
            load(next_q, svc_pkg::MSG_SAVE_ABORTED, svc_pkg::MSG_ERR_PARAM,
                 svc_pkg::MSG_PROMPT, svc_pkg::MSG_NONE);
          end
        end
      end
      svc_pkg::ST_CONF_EXIT: begin
        if (take) begin
          if (rx_data == `CH_YES) begin
            load(next_q, to_init ? svc_pkg::MSG_TO_INIT : svc_pkg::MSG_TO_NORMAL,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
            next_timing = 1'b0;
            next_state  = svc_pkg::ST_HOLD;
          end else if (rx_data == `CH_NO) begin
            load(next_q, svc_pkg::MSG_PROMPT, svc_pkg::MSG_NONE,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
            next_state = svc_pkg::ST_IDLE;
          end else begin
            load(next_q, svc_pkg::MSG_ERR_PARAM, svc_pkg::MSG_PROMPT,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
            next_state = svc_pkg::ST_IDLE;
          end
        end
      end
      svc_pkg::ST_CONF_REST, svc_pkg::ST_CONF_TX: begin
        if (take) begin
          next_state = svc_pkg::ST_IDLE;
          if (rx_data != `CH_YES) begin
            load(next_q, (rx_data == `CH_NO) ? svc_pkg::MSG_PROMPT : svc_pkg::MSG_ERR_PARAM,
                 (rx_data == `CH_NO) ? svc_pkg::MSG_NONE : svc_pkg::MSG_PROMPT,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
          end else if (state == svc_pkg::ST_CONF_REST && tx_settings_differ) begin
            load(next_q, svc_pkg::MSG_TX_CONFIRM, svc_pkg::MSG_NONE,
                 svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
            next_state = svc_pkg::ST_CONF_TX;
          end else begin
            // Defaults go to the live set only; flash is written by save alone.
            next_apply_defaults = 1'b1;
            load(next_q, (state == svc_pkg::ST_CONF_TX) ? svc_pkg::MSG_TX_NEW
                 : svc_pkg::MSG_APPLYING,
                 (state == svc_pkg::ST_CONF_TX) ? svc_pkg::MSG_APPLYING
                 : svc_pkg::MSG_APPLIED,
                 (state == svc_pkg::ST_CONF_TX) ? svc_pkg::MSG_APPLIED
                 : svc_pkg::MSG_PROMPT,
                 (state == svc_pkg::ST_CONF_TX) ? svc_pkg::MSG_PROMPT
                 : svc_pkg::MSG_NONE);
          end
        end
      end
      svc_pkg::ST_HOLD: begin
        // The hold starts only once the last code has been handed over.
        if (!timing && q_empty) begin
          hold.start  = 1'b1;
          next_timing = 1'b1;
        end else if (hold.done) begin
          next_enter_normal = !to_init;
          next_enter_init   = to_init;
          next_load_flash   = to_init;
          next_state        = svc_pkg::ST_LEFT;
        end
      end
      svc_pkg::ST_LEFT: begin
        if (enter_service) begin
          load(next_q, svc_pkg::MSG_PROMPT, svc_pkg::MSG_NONE,
               svc_pkg::MSG_NONE, svc_pkg::MSG_NONE);
          next_state = svc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = svc_pkg::ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      state          <= svc_pkg::ST_IDLE;
      q              <= '{default: svc_pkg::MSG_NONE};
      cmd            <= `CHAR_RESET;
      first_ch       <= `CHAR_RESET;
      second_ch      <= `CHAR_RESET;
      n_after        <= `COUNT_RESET;
      comma          <= 1'b0;
      to_init        <= 1'b0;
      timing         <= 1'b0;
      save_req       <= 1'b0;
      load_flash     <= 1'b0;
      apply_defaults <= 1'b0;
      enter_normal   <= 1'b0;
      enter_init     <= 1'b0;
    end else begin
      state          <= next_state;
      q              <= next_q;
      cmd            <= next_cmd;
      first_ch       <= next_first_ch;
      second_ch      <= next_second_ch;
      n_after        <= next_n_after;
      comma          <= next_comma;
      to_init        <= next_to_init;
      timing         <= next_timing;
      save_req       <= next_save_req;
      load_flash     <= next_load_flash;
      apply_defaults <= next_apply_defaults;
      enter_normal   <= next_enter_normal;
      enter_init     <= next_enter_init;
    end
  end
endmodule : service_mode_exit_restore

// ### verification/svc_checker_assertions.sv
/*
  Port checker for the service-mode handler: exits, hold time, saves and restores.
  Assumes it is bound to the handler and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "svc_map.svh"
module svc_checker #(
  parameter logic [31:0] HOLD_CYCLES = 32'h0000_0014
) (
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    rst,
  // Characters
  input  wire logic [7:0] rx_data,
  input  wire logic    rx_valid,
  input  wire logic    rx_ready,
  // Messages
  input  svc_pkg::msg_t msg_code,
  input  wire logic    msg_valid,
  input  wire logic    msg_ready,
  // Configuration store
  input  wire logic    params_differ,
  input  wire logic    tx_settings_differ,
  input  wire logic    save_req,
  input  wire logic    load_flash,
  input  wire logic    apply_defaults,
  // Mode control
  input  wire logic    enter_service,
  input  wire logic    enter_normal,
  input  wire logic    enter_init
);
  // ==========
  // History of taken characters and quiet time
  // The last three characters tell an immediate exit from a held one.
  logic        take;
  logic        imm;
  logic [23:0] hist;
  logic [23:0] next_hist;
  logic [31:0] quiet;
  logic [31:0] next_quiet;
  assign take = rx_valid & rx_ready;
  assign imm = hist[7:0] == `CH_CR && hist[23:16] == `CH_SPACE &&
               (hist[15:8] == `CH_T_NOW_NRM || hist[15:8] == `CH_T_NOW_INI);
  always_comb begin
    next_hist = take ? {hist[15:0], rx_data} : hist;
    next_quiet = (take | msg_valid) ? 32'h0000_0000 : quiet + 32'h0000_0001;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      hist <= 24'h00_0000;
      quiet <= 32'h0000_0000;
    end else begin
      hist <= next_hist;
      quiet <= next_quiet;
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_now_normal;
    take && rx_data == `CH_CR && hist == {`CH_EXIT, `CH_SPACE, `CH_T_NOW_NRM} |=> enter_normal;
  endproperty
  a_now_normal: assert property (p_now_normal) else $error("immediate normal exit late");
  property p_now_init;
    take && rx_data == `CH_CR && hist == {`CH_EXIT, `CH_SPACE, `CH_T_NOW_INI}
      |=> enter_init && load_flash;
  endproperty
  a_now_init: assert property (p_now_init) else $error("immediate init exit late");
  property p_init_reload;
    enter_init || load_flash |-> enter_init && load_flash;
  endproperty
  a_init_reload: assert property (p_init_reload) else $error("init without reload");
  property p_hold;
    (enter_normal || enter_init) && !imm |-> quiet >= HOLD_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("exit before hold time");
  property p_save_cause;
    save_req |-> hist[7:0] == `CH_YES;
  endproperty
  a_save_cause: assert property (p_save_cause) else $error("save without Y");
  property p_defaults_cause;
    apply_defaults |-> hist[7:0] == `CH_YES && !save_req;
  endproperty
  a_defaults_cause: assert property (p_defaults_cause) else $error("bad restore");
  property p_exit_cause;
    enter_normal |-> hist[7:0] == `CH_CR || hist[7:0] == `CH_YES;
  endproperty
  a_exit_cause: assert property (p_exit_cause) else $error("exit without Y");
  property p_stands;
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_code);
  endproperty
  a_stands: assert property (p_stands) else $error("message code dropped");
  property p_refuse;
    msg_valid || enter_normal || enter_init |-> !rx_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("character taken mid reply");
  c_normal: cover property (enter_normal);
  c_init: cover property (enter_init);
  c_defaults: cover property (apply_defaults);
endmodule : svc_checker

bind service_mode_exit_restore svc_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
  .clock(clock), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .msg_code(msg_code), .msg_valid(msg_valid), .msg_ready(msg_ready),
  .params_differ(params_differ), .tx_settings_differ(tx_settings_differ),
  .save_req(save_req), .load_flash(load_flash), .apply_defaults(apply_defaults),
  .enter_service(enter_service), .enter_normal(enter_normal), .enter_init(enter_init));

// ### verification/host_model.sv
/*
  Host terminal model: sends queued characters and logs message codes.
  Assumes the bench fills tx_q and reads got_q by hierarchical reference.
*/
`timescale 1ns/1ps
module host_model (
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    rst,
  // Characters toward the device
  output logic [7:0]   rx_data,
  output logic         rx_valid,
  input  wire logic    rx_ready,
  // Messages from the device
  input  svc_pkg::msg_t msg_code,
  input  wire logic    msg_valid,
  output logic         msg_ready,
  // Pacing
  input  wire logic    slow
);
  logic [7:0]    tx_q[$];
  svc_pkg::msg_t got_q[$];
  logic          taken = 1'b0;
  logic          phase = 1'b0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    msg_ready = 1'b1;
  end
  always @(posedge clock) begin
    taken <= rx_valid & rx_ready;
    if (msg_valid && msg_ready) begin
      got_q.push_back(msg_code);
    end
  end
  // Idle data toggles so a stale character is never mistaken for a fresh one.
  always @(negedge clock) begin
    phase <= ~phase;
    msg_ready <= ~slow | phase;
    if (rst) begin
      rx_valid <= 1'b0;
    end else if (!rx_valid || taken) begin
      if (tx_q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data <= tx_q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
endmodule : host_model

// ### verification/tb_top.sv
/*
  Self-checking bench for the service-mode handler.
  Assumes the handler, its checker and the host model are compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] HOLD = 32'h0000_0014;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          slow = 1'b0;
  logic          params_differ = 1'b0;
  logic          tx_settings_differ = 1'b0;
  logic          enter_service = 1'b0;
  logic [7:0]    rx_data;
  logic          rx_valid, rx_ready, msg_valid, msg_ready;
  svc_pkg::msg_t msg_code;
  logic          save_req, load_flash, apply_defaults, enter_normal, enter_init;
  logic [31:0]   n_save = 0, n_load = 0, n_def = 0, n_norm = 0, n_init = 0;
  int            n_mismatch = 0;
  int            checks = 0;

  always #4 clock = ~clock;
  always @(posedge clock) begin
    n_save <= n_save + 32'(save_req);
    n_load <= n_load + 32'(load_flash);
    n_def <= n_def + 32'(apply_defaults);
    n_norm <= n_norm + 32'(enter_normal);
    n_init <= n_init + 32'(enter_init);
  end

  service_mode_exit_restore #(.HOLD_CYCLES(HOLD)) uut (
    .clock(clock), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .msg_code(msg_code), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .params_differ(params_differ), .tx_settings_differ(tx_settings_differ),
    .save_req(save_req), .load_flash(load_flash), .apply_defaults(apply_defaults),
    .enter_service(enter_service), .enter_normal(enter_normal), .enter_init(enter_init));
  host_model host (
    .clock(clock), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .msg_code(msg_code), .msg_valid(msg_valid), .msg_ready(msg_ready), .slow(slow));

  // ==========
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) host.tx_q.push_back(s[i]);
  endtask : send
  task automatic clr;
    {n_save, n_load, n_def, n_norm, n_init} = '0;
  endtask : clr
  task automatic expect_codes(input svc_pkg::msg_t c0, c1 = svc_pkg::MSG_NONE,
                              c2 = svc_pkg::MSG_NONE, c3 = svc_pkg::MSG_NONE,
                              c4 = svc_pkg::MSG_NONE, c5 = svc_pkg::MSG_NONE);
    svc_pkg::msg_t e[6];
    int n;
    e = '{c0, c1, c2, c3, c4, c5};
    n = 0;
    while (n < 6 && e[n] != svc_pkg::MSG_NONE) n++;
    for (int k = 0; k < 3000 && host.got_q.size() < n; k++) @(negedge clock);
    repeat (6) @(negedge clock);
    chk(host.got_q.size(), n);
    for (int k = 0; k < n && k < host.got_q.size(); k++) chk(host.got_q[k], e[k]);
    host.got_q.delete();
  endtask : expect_codes
  task automatic back;
    @(negedge clock);
    enter_service = 1'b1;
    @(negedge clock);
    enter_service = 1'b0;
    expect_codes(svc_pkg::MSG_PROMPT);
  endtask : back
  task automatic wait_exit(output int k);
    for (k = 0; k < 500 && n_norm + n_init == 0; k++) @(negedge clock);
  endtask : wait_exit

  // ==========
  // Scenarios
  task automatic t_errors;
    string line[7] = '{"\015", "q\015", "x,n\015", "x\015", "z 1\015", "x q\015", "x n5\015"};
    svc_pkg::msg_t err[7] = '{svc_pkg::MSG_NONE, svc_pkg::MSG_ERR_UNKNOWN,
      svc_pkg::MSG_ERR_COUNT, svc_pkg::MSG_ERR_COUNT, svc_pkg::MSG_ERR_COUNT,
      svc_pkg::MSG_ERR_PARAM, svc_pkg::MSG_ERR_PARAM};
    send(line[0]);
    expect_codes(svc_pkg::MSG_PROMPT);
    for (int i = 1; i < 7; i++) begin
      send(line[i]);
      expect_codes(err[i], svc_pkg::MSG_PROMPT);
    end
  endtask : t_errors
  task automatic t_save;
    clr();
    send("s\015N");
    expect_codes(svc_pkg::MSG_SAVE_CONFIRM, svc_pkg::MSG_SAVE_ABORTED, svc_pkg::MSG_PROMPT);
    send("s\015y");
    expect_codes(svc_pkg::MSG_SAVE_CONFIRM, svc_pkg::MSG_SAVE_ABORTED,
                 svc_pkg::MSG_ERR_PARAM, svc_pkg::MSG_PROMPT);
    chk(n_save, 0);
    send("s\015Y");
    expect_codes(svc_pkg::MSG_SAVE_CONFIRM, svc_pkg::MSG_SAVE_DONE, svc_pkg::MSG_PROMPT);
    chk(n_save, 1);
  endtask : t_save
  task automatic t_exit_refuse;
    clr();
    params_differ = 1'b1;
    send("x n\015n");
    expect_codes(svc_pkg::MSG_EXIT_CONFIRM, svc_pkg::MSG_ERR_PARAM, svc_pkg::MSG_PROMPT);
    send("x i\015N");
    expect_codes(svc_pkg::MSG_EXIT_CONFIRM, svc_pkg::MSG_PROMPT);
    chk(n_norm + n_init, 0);
  endtask : t_exit_refuse
  task automatic t_exit_hold;
    int k;
    slow = 1'b1;
    for (int j = 0; j < 2; j++) begin
      clr();
      params_differ = (j == 0);
      send(j == 0 ? "x n\015Y" : "x i\015");
      wait_exit(k);
      chk(k > HOLD && k < HOLD + 40, 1);
      expect_codes(j == 0 ? svc_pkg::MSG_EXIT_CONFIRM : svc_pkg::MSG_TO_INIT,
                   j == 0 ? svc_pkg::MSG_TO_NORMAL : svc_pkg::MSG_NONE);
      chk({n_norm, n_init, n_load}, {32'(1 - j), 32'(j), 32'(j)});
      back();
    end
    slow = 1'b0;
  endtask : t_exit_hold
  task automatic t_exit_now;
    int k;
    params_differ = 1'b1;
    for (int j = 0; j < 2; j++) begin
      clr();
      send(j == 0 ? "x N\015" : "x I\015");
      wait_exit(k);
      chk(k < 10, 1);
      expect_codes(j == 0 ? svc_pkg::MSG_TO_NORMAL : svc_pkg::MSG_TO_INIT);
      chk({n_norm, n_init, n_load}, {32'(1 - j), 32'(j), 32'(j)});
      back();
    end
  endtask : t_exit_now
  task automatic t_restore;
    clr();
    slow = 1'b1;
    send("z\015Y");
    expect_codes(svc_pkg::MSG_REST_CONFIRM, svc_pkg::MSG_APPLYING,
                 svc_pkg::MSG_APPLIED, svc_pkg::MSG_PROMPT);
    tx_settings_differ = 1'b1;
    send("z\015YY");
    expect_codes(svc_pkg::MSG_REST_CONFIRM, svc_pkg::MSG_TX_CONFIRM, svc_pkg::MSG_TX_NEW,
                 svc_pkg::MSG_APPLYING, svc_pkg::MSG_APPLIED, svc_pkg::MSG_PROMPT);
    send("z\015YN");
    expect_codes(svc_pkg::MSG_REST_CONFIRM, svc_pkg::MSG_TX_CONFIRM, svc_pkg::MSG_PROMPT);
    send("z\015N");
    expect_codes(svc_pkg::MSG_REST_CONFIRM, svc_pkg::MSG_PROMPT);
    chk({n_def, n_save}, {32'h0000_0002, 32'h0000_0000});
    slow = 1'b0;
  endtask : t_restore

  // ==========
  // Verdict and main sequence
  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    t_errors();
    t_save();
    t_exit_refuse();
    t_exit_hold();
    t_exit_now();
    t_restore();
    give_verdict();
  end
  // The whole run takes a few hundred cycles; this limit of 50000 cycles is far beyond it.
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_top
